// ---- rtl/pmc_ctrl.sv ----
// Purpose: Configuration and control registers of a power/current monitor
// Assumes: Register port is the decoded serial management bus, one byte per access
// Notes: Integrate/read pin is high for integrate; sleep timeout is shortenable
`timescale 1ns/1ps
// Summary of operation
// [R1] Config bit 3 enables sense post filter, bit 2 enables bus post filter.
// [R2] An enabled post filter makes that sample type's conversion half again longer.
// [R3] With config bit 1 set, pin ignored and config bit 0 forces integrate.
// [R4] Control register at 02h: eight read/write bits, all zero after reset.
// [R5] Control bits 5-4 pick output full scale: 3V, 2V, 1.5V, 1.0V.
// [R6] Writing one to control bit 2 while in Read enters Sleep.
// [R7] Control bit 1 set disables the sleep timer, device stays in Read.
// [R8] Control bit 0 written one recalculates and updates the output at once.
module pmc_ctrl #(
  parameter int SLEEP_CYCLES = pmc_pkg::PMC_SLEEP_CYCLES,
  parameter int SLEEP_W = 16
) (
  input wire logic ref_clk,
  input wire logic sys_rst,
  input wire logic read_int_pin,
  input wire logic reg_wr_en,
  input wire logic reg_rd_en,
  input wire logic [7:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  output logic [7:0] reg_rdata,
  output logic sense_filter_enable,
  output logic bus_filter_enable,
  output logic [1:0] output_full_scale_select,
  output logic integrating,
  output logic sleeping,
  output logic dac_update,
  output logic sample_strobe,
  output logic sample_is_bus
);

  generate
    if (SLEEP_CYCLES < 2 || SLEEP_CYCLES >= (1 << SLEEP_W)) begin : g_chk
      $error("pmc_ctrl: SLEEP_CYCLES does not fit the sleep counter");
    end
  endgenerate

  typedef struct packed {
    logic [7:0] cfg;
    logic [7:0] ctrl;
    pmc_pkg::pmc_state_type st;
    logic [SLEEP_W-1:0] sleep_cnt;
    logic [7:0] rdata;
    logic dac_update;
    logic integ;
    logic asleep;
  } pmc_ctrl_state_type;

  pmc_ctrl_state_type s_r;
  pmc_ctrl_state_type s_nxt;
  pmc_pkg::pmc_reg_req_type req;
  logic integ_req;
  logic wr_cfg;
  logic wr_ctrl;

  // Address match shared by read and write paths
  function automatic logic addr_is(input logic [7:0] a, input logic [7:0] ref_a);
    return a == ref_a;
  endfunction

  // Bus request bundle and decode
  assign req = '{wr_en: reg_wr_en, rd_en: reg_rd_en, addr: reg_addr, wdata: reg_wdata};
  assign wr_cfg = req.wr_en && addr_is(req.addr, pmc_pkg::PMC_CFG_ADDR);
  assign wr_ctrl = req.wr_en && addr_is(req.addr, pmc_pkg::PMC_CTRL_ADDR);

  // Integrate request: software override replaces the pin
  assign integ_req = s_r.cfg[pmc_pkg::PMC_CFG_PIN_OVR] ? // [R3]
    s_r.cfg[pmc_pkg::PMC_CFG_FORCE_INT] : read_int_pin;

  // Next-state: registers, readback and operating state
  always_comb begin
    s_nxt = s_r;
    s_nxt.dac_update = 1'b0;
    if (wr_cfg) begin
      s_nxt.cfg = req.wdata; // [R1]
    end
    if (wr_ctrl) begin
      s_nxt.ctrl = req.wdata; // [R4]
    end
    if (req.rd_en) begin
      if (addr_is(req.addr, pmc_pkg::PMC_CFG_ADDR)) begin
        s_nxt.rdata = s_r.cfg;
      end else if (addr_is(req.addr, pmc_pkg::PMC_CTRL_ADDR)) begin
        s_nxt.rdata = s_r.ctrl; // [R4]
      end else begin
        s_nxt.rdata = pmc_pkg::PMC_UNMAPPED_READ;
      end
    end
    // Immediate recalculation on a write of one
    if (wr_ctrl && req.wdata[pmc_pkg::PMC_CTRL_RECALC]) begin
      s_nxt.dac_update = 1'b1; // [R8]
    end
    case (s_r.st)
      pmc_pkg::PMC_ST_INTEG: begin
        s_nxt.sleep_cnt = '0;
        if (!integ_req) begin
          s_nxt.st = pmc_pkg::PMC_ST_READ;
          s_nxt.dac_update = 1'b1;
        end
      end
      pmc_pkg::PMC_ST_READ: begin
        if (integ_req) begin
          s_nxt.st = pmc_pkg::PMC_ST_INTEG;
          s_nxt.sleep_cnt = '0;
        end else if (wr_ctrl && req.wdata[pmc_pkg::PMC_CTRL_SLEEP]) begin
          s_nxt.st = pmc_pkg::PMC_ST_SLEEP; // [R6]
        end else if (s_r.ctrl[pmc_pkg::PMC_CTRL_SLEEP_OVR]) begin
          s_nxt.sleep_cnt = '0; // [R7]
        end else if (s_r.sleep_cnt == SLEEP_W'(SLEEP_CYCLES - 1)) begin
          s_nxt.st = pmc_pkg::PMC_ST_SLEEP;
        end else begin
          s_nxt.sleep_cnt = s_r.sleep_cnt + SLEEP_W'(1);
        end
      end
      pmc_pkg::PMC_ST_SLEEP: begin
        s_nxt.sleep_cnt = '0;
        if (integ_req) begin
          s_nxt.st = pmc_pkg::PMC_ST_INTEG;
        end
      end
      default: begin
        s_nxt.st = pmc_pkg::PMC_ST_INTEG;
      end
    endcase
    // Flags decoded ahead of the register so the outputs leave flip-flops
    s_nxt.integ = (s_nxt.st == pmc_pkg::PMC_ST_INTEG);
    s_nxt.asleep = (s_nxt.st == pmc_pkg::PMC_ST_SLEEP);
  end

  // State register
  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      s_r.cfg <= pmc_pkg::PMC_CFG_RESET;
      s_r.ctrl <= pmc_pkg::PMC_CTRL_RESET;
      s_r.st <= pmc_pkg::PMC_ST_INTEG;
      s_r.sleep_cnt <= '0;
      s_r.rdata <= 8'h00;
      s_r.dac_update <= 1'b0;
      s_r.integ <= 1'b1;
      s_r.asleep <= 1'b0;
    end else begin
      s_r <= s_nxt;
    end
  end

  // Outputs straight from the state register
  assign reg_rdata = s_r.rdata;
  assign sense_filter_enable = s_r.cfg[pmc_pkg::PMC_CFG_SENSE_FILT]; // [R1]
  assign bus_filter_enable = s_r.cfg[pmc_pkg::PMC_CFG_BUS_FILT]; // [R1]
  assign output_full_scale_select =
    s_r.ctrl[pmc_pkg::PMC_CTRL_FSR_HI:pmc_pkg::PMC_CTRL_FSR_LO]; // [R5]
  assign integrating = s_r.integ;
  assign sleeping = s_r.asleep;
  assign dac_update = s_r.dac_update;

  // Conversion timing while integrating
  pmc_conv_seq u_seq (
    .ref_clk(ref_clk),
    .sys_rst(sys_rst),
    .run(integrating),
    .sense_filt(s_r.cfg[pmc_pkg::PMC_CFG_SENSE_FILT]),
    .bus_filt(s_r.cfg[pmc_pkg::PMC_CFG_BUS_FILT]),
    .strobe(sample_strobe),
    .is_bus(sample_is_bus)
  );

  default clocking @(posedge ref_clk); endclocking
  default disable iff (sys_rst);

  chk_filter_follow: assert property (wr_cfg |=> // [R1]
    sense_filter_enable == $past(reg_wdata[3]) && bus_filter_enable == $past(reg_wdata[2]))
    else $error("filter enables do not follow config write");
  chk_override_force: assert property ( // [R3]
    s_r.cfg[1] && s_r.cfg[0] |=> integrating)
    else $error("forced integrate not entered");
  chk_override_pin: assert property ( // [R3]
    s_r.cfg[1] && !s_r.cfg[0] && integrating |=> !integrating)
    else $error("pin not ignored under override");
  chk_ctrl_readback: assert property ( // [R4]
    reg_rd_en && reg_addr == 8'h02 && !reg_wr_en |=> reg_rdata == $past(s_r.ctrl))
    else $error("control readback wrong");
  chk_ctrl_reset: assert property (@(posedge ref_clk) // [R4]
    $fell(sys_rst) |-> s_r.ctrl == 8'h00 && s_r.cfg == 8'h00)
    else $error("registers not zero after reset");
  chk_fsr_map: assert property (wr_ctrl |=> // [R5]
    output_full_scale_select == $past(reg_wdata[5:4]))
    else $error("full scale select mismatch");
  chk_sleep_write: assert property ( // [R6]
    s_r.st == pmc_pkg::PMC_ST_READ && !integ_req && wr_ctrl && reg_wdata[2] |=> sleeping)
    else $error("sleep write did not enter sleep");
  chk_sleep_ovr: assert property ( // [R7]
    s_r.st == pmc_pkg::PMC_ST_READ && s_r.ctrl[1] && !integ_req && !wr_ctrl |=> !sleeping)
    else $error("sleep timer not overridden");
  chk_recalc_pulse: assert property ( // [R8]
    wr_ctrl && reg_wdata[0] |=> dac_update ##1 !dac_update || $past(integrating))
    else $error("recalculate did not pulse output update");
  chk_pin_follow: assert property ( // [R3]
    !s_r.cfg[1] |=> integrating == $past(read_int_pin))
    else $error("state does not follow the pin without override");
  chk_cfg_readback: assert property ( // [R1]
    reg_rd_en && reg_addr == 8'h00 && !reg_wr_en |=> reg_rdata == $past(s_r.cfg))
    else $error("config readback wrong");
  chk_dac_on_read: assert property ( // [R8]
    integrating && !integ_req |=> dac_update)
    else $error("no output update on leaving integrate");
  chk_sleep_hold: assert property ( // [R6]
    sleeping && !integ_req |=> sleeping)
    else $error("sleep left without integrate request");
  chk_fsr_hold: assert property ( // [R5]
    !wr_ctrl |=> $stable(output_full_scale_select))
    else $error("full scale select changed without write");

  // Main scenarios reached by the bench
  cov_sleep_write: cover property (s_r.st == pmc_pkg::PMC_ST_READ && wr_ctrl ##1 sleeping);
  cov_timed_sleep: cover property (
    s_r.st == pmc_pkg::PMC_ST_READ ##1 sleeping && !$past(wr_ctrl));
  cov_forced_int: cover property (s_r.cfg[1] && s_r.cfg[0] ##1 integrating);
  cov_filtered_bus: cover property (sample_strobe && sample_is_bus && bus_filter_enable);

endmodule

// ---- rtl/pmc_pkg.sv ----
// Purpose: Shared constants and types for the power monitor control block
// Assumes: ref_clk at 10 MHz, registers reached by the decoded serial bus port
// Notes: Conversion and sleep times are given in ns and turned into cycles here
package pmc_pkg;

  // Register addresses
  localparam logic [7:0] PMC_CFG_ADDR = 8'h00;
  localparam logic [7:0] PMC_CTRL_ADDR = 8'h02;

  // Integration configuration fields
  localparam int PMC_CFG_FORCE_INT = 0;
  localparam int PMC_CFG_PIN_OVR = 1;
  localparam int PMC_CFG_BUS_FILT = 2;
  localparam int PMC_CFG_SENSE_FILT = 3;

  // Measurement control fields
  localparam int PMC_CTRL_RECALC = 0;
  localparam int PMC_CTRL_SLEEP_OVR = 1;
  localparam int PMC_CTRL_SLEEP = 2;
  localparam int PMC_CTRL_FSR_LO = 4;
  localparam int PMC_CTRL_FSR_HI = 5;

  // Reset values and unmapped read value
  localparam logic [7:0] PMC_CFG_RESET = 8'h00;
  localparam logic [7:0] PMC_CTRL_RESET = 8'h00;
  localparam logic [7:0] PMC_UNMAPPED_READ = 8'h00;

  // Full-scale range codes
  localparam logic [1:0] PMC_FSR_3V0 = 2'h0;
  localparam logic [1:0] PMC_FSR_2V0 = 2'h1;
  localparam logic [1:0] PMC_FSR_1V5 = 2'h2;
  localparam logic [1:0] PMC_FSR_1V0 = 2'h3;

  // Timing
  localparam int PMC_CLK_PERIOD_NS = 100;
  localparam int PMC_CONV_TIME_NS = 10000;
  localparam int PMC_CONV_CYCLES = (PMC_CONV_TIME_NS + PMC_CLK_PERIOD_NS - 1) / PMC_CLK_PERIOD_NS;
  localparam int PMC_FILT_CYCLES = PMC_CONV_CYCLES + PMC_CONV_CYCLES / 2;
  localparam int PMC_SLEEP_TIMEOUT_NS = 1000000;
  localparam int PMC_SLEEP_CYCLES = PMC_SLEEP_TIMEOUT_NS / PMC_CLK_PERIOD_NS;

  // Operating states
  typedef enum logic [1:0] {
    PMC_ST_INTEG = 2'b00,
    PMC_ST_READ = 2'b01,
    PMC_ST_SLEEP = 2'b10
  } pmc_state_type;

  // Register access request, read and write
  typedef struct packed {
    logic wr_en;
    logic rd_en;
    logic [7:0] addr;
    logic [7:0] wdata;
  } pmc_reg_req_type;

endpackage

// ---- rtl/pmc_conv_seq.sv ----
// Purpose: Alternating sense/bus sample conversion timer
// Assumes: Filter enables are steady within one conversion
// Notes: A filtered conversion lasts half again as long as a plain one
`timescale 1ns/1ps
module pmc_conv_seq #(
  parameter int CONV_CYCLES = pmc_pkg::PMC_CONV_CYCLES,
  parameter int FILT_CYCLES = pmc_pkg::PMC_FILT_CYCLES,
  parameter int CNT_W = 12
) (
  input wire logic ref_clk,
  input wire logic sys_rst,
  input wire logic run,
  input wire logic sense_filt,
  input wire logic bus_filt,
  output logic strobe,
  output logic is_bus
);

  generate
    if (CONV_CYCLES < 2 || FILT_CYCLES < CONV_CYCLES || FILT_CYCLES >= (1 << CNT_W)) begin : g_chk
      $error("pmc_conv_seq: conversion counts out of range");
    end
  endgenerate

  typedef struct packed {
    logic [CNT_W-1:0] cnt;
    logic [CNT_W-1:0] lim;
    logic phase_bus;
    logic strobe;
    logic is_bus;
  } pmc_seq_state_type;

  pmc_seq_state_type s_r;
  pmc_seq_state_type s_nxt;

  // Next-state: count one conversion, then switch sample type
  always_comb begin
    s_nxt = s_r;
    s_nxt.strobe = 1'b0;
    if (!run) begin
      s_nxt.cnt = '0;
      s_nxt.phase_bus = 1'b0;
    end else begin
      if (s_r.cnt == '0) begin
        // Lengthen by half when the matching filter is on [R2]
        if (s_r.phase_bus ? bus_filt : sense_filt) begin
          s_nxt.lim = CNT_W'(FILT_CYCLES - 1);
        end else begin
          s_nxt.lim = CNT_W'(CONV_CYCLES - 1);
        end
      end
      if (s_r.cnt != '0 && s_r.cnt == s_r.lim) begin
        s_nxt.cnt = '0;
        s_nxt.strobe = 1'b1;
        s_nxt.is_bus = s_r.phase_bus;
        s_nxt.phase_bus = ~s_r.phase_bus;
      end else begin
        s_nxt.cnt = s_r.cnt + CNT_W'(1);
      end
    end
  end

  // State register
  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      s_r <= '0;
    end else begin
      s_r <= s_nxt;
    end
  end

  assign strobe = s_r.strobe;
  assign is_bus = s_r.is_bus;

  // Helper: cycles since conversion start and filter used for it
  logic [CNT_W-1:0] gap_r;
  logic filt_used_r;
  always_ff @(posedge ref_clk) begin
    if (sys_rst || !run) begin
      gap_r <= '0;
      filt_used_r <= 1'b0;
    end else begin
      // A strobe cycle is already the first cycle of the next conversion
      if (s_r.strobe) begin
        gap_r <= CNT_W'(1);
      end else begin
        gap_r <= gap_r + CNT_W'(1);
      end
      if (s_r.strobe || gap_r == '0) begin
        filt_used_r <= s_r.phase_bus ? bus_filt : sense_filt;
      end
    end
  end

  chk_conv_length: assert property (@(posedge ref_clk) disable iff (sys_rst) // [R2]
    $rose(s_r.strobe) && $past(run) |->
      gap_r == CNT_W'(filt_used_r ? FILT_CYCLES : CONV_CYCLES))
    else $error("conversion length does not match filter setting");

endmodule

// ---- tb/pmc_host.sv ----
// Purpose: Host model driving the decoded register port of the control block
// Assumes: One byte per access, strobes driven at the falling edge
// Notes: Idle address and data show the inverse of the last value
`timescale 1ns/1ps
module pmc_host (
  input wire logic ref_clk,
  output logic reg_wr_en,
  output logic reg_rd_en,
  output logic [7:0] reg_addr,
  output logic [7:0] reg_wdata,
  input wire logic [7:0] reg_rdata
);
  initial begin
    reg_wr_en = 1'b0;
    reg_rd_en = 1'b0;
    reg_addr = 8'h00;
    reg_wdata = 8'h00;
  end
  // Single byte write, sleep requests included
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(negedge ref_clk);
    reg_wr_en = 1'b1;
    reg_addr = a;
    reg_wdata = d;
    @(negedge ref_clk);
    reg_wr_en = 1'b0;
    reg_addr = ~a;
    reg_wdata = ~d;
  endtask
  // Single byte read, data taken one cycle after the strobe
  task automatic rd(input logic [7:0] a, output logic [7:0] d);
    @(negedge ref_clk);
    reg_rd_en = 1'b1;
    reg_addr = a;
    @(negedge ref_clk);
    reg_rd_en = 1'b0;
    reg_addr = ~a;
    d = reg_rdata;
  endtask
endmodule

// ---- tb/testbench.sv ----
// Purpose: Self-checking bench for the power monitor control registers
// Assumes: Short sleep timeout of 20 cycles
// Notes: Conversion lengths judged from strobe spacing per sample type
`timescale 1ns/1ps
module testbench;
  logic ref_clk, sys_rst, read_int_pin, wr_en, rd_en;
  logic [7:0] addr, wdata, rdata, v;
  logic sfe, bfe, integ, slp, dac, strb, isb;
  logic [1:0] fsr;
  int miscompares = 0, n_tests = 0, cyc = 0, last = 0, ts = 0, tbus = 0, n_dac = 0, d0;
  logic [7:0] cfgs [3] = '{8'h00, 8'h08, 8'h04};
  localparam int conv_len = pmc_pkg::PMC_CONV_CYCLES;
  localparam int filt_len = pmc_pkg::PMC_FILT_CYCLES;

  pmc_host u_host (.ref_clk(ref_clk), .reg_wr_en(wr_en), .reg_rd_en(rd_en),
    .reg_addr(addr), .reg_wdata(wdata), .reg_rdata(rdata));
  pmc_ctrl #(.SLEEP_CYCLES(20)) DUT (.ref_clk(ref_clk), .sys_rst(sys_rst),
    .read_int_pin(read_int_pin), .reg_wr_en(wr_en), .reg_rd_en(rd_en), .reg_addr(addr),
    .reg_wdata(wdata), .reg_rdata(rdata), .sense_filter_enable(sfe),
    .bus_filter_enable(bfe), .output_full_scale_select(fsr), .integrating(integ),
    .sleeping(slp), .dac_update(dac), .sample_strobe(strb), .sample_is_bus(isb));

  // Clock at 100 ns
  initial begin
    ref_clk = 1'b0;
    forever #50 ref_clk = ~ref_clk;
  end
  // Spans between samples and update pulses
  always @(negedge ref_clk) begin
    cyc++;
    if (strb === 1'b1) begin
      if (isb === 1'b1) tbus = cyc - last;
      else ts = cyc - last;
      last = cyc;
    end
    if (dac === 1'b1) n_dac++;
  end

  task automatic chk(input string nm, input logic [15:0] e, input logic [15:0] g);
    n_tests++;
    if (g !== e) begin
      miscompares++;
      $display("FAIL %s expected %h seen %h", nm, e, g);
    end
  endtask
  task automatic complete_run();
    $display("comparisons %0d mismatches %0d", n_tests, miscompares);
    if (miscompares == 0 && n_tests > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask
  // Watchdog
  initial begin
    #(100 * 20000);
    miscompares++;
    complete_run();
  end

  initial begin
    sys_rst = 1'b1;
    read_int_pin = 1'b1;
    repeat (12) @(negedge ref_clk);
    sys_rst = 1'b0;
    // Reset values and unmapped read
    u_host.rd(8'h02, v); chk("ctrl", 8'h00, v);
    u_host.rd(8'h05, v); chk("unmapped", 8'h00, v);
    chk("outs", 16'h0002, {sfe, bfe, fsr, integ, slp});
    $display("test reset done");
    // Full scale codes and recalculate pulses
    d0 = n_dac;
    for (int i = 0; i < 4; i++) begin
      u_host.wr(8'h02, {2'h0, i[1:0], 4'h1});
      chk("fsr", i[1:0], fsr);
      u_host.rd(8'h02, v); chk("ctrl rb", {2'h0, i[1:0], 4'h1}, v);
    end
    u_host.wr(8'h02, 8'hc8);
    u_host.rd(8'h02, v); chk("ctrl rb", 8'hc8, v);
    u_host.wr(8'h02, 8'h00);
    chk("dac pulses", 4, n_dac - d0);
    $display("test control done");
    // Post filters lengthen conversions by half
    foreach (cfgs[k]) begin
      u_host.wr(8'h00, cfgs[k]);
      chk("filt", cfgs[k][3:2], {sfe, bfe});
      u_host.rd(8'h00, v); chk("cfg rb", cfgs[k], v);
      repeat (700) @(negedge ref_clk);
      chk("span diff", 16'h0100 + 50 * cfgs[k][3] - 50 * cfgs[k][2],
          16'h0100 + ts - tbus);
      chk("sense span", cfgs[k][3] ? filt_len : conv_len, ts);
      chk("bus span", cfgs[k][2] ? filt_len : conv_len, tbus);
    end
    $display("test filter done");
    // Pin override
    u_host.wr(8'h00, 8'h02);
    @(negedge ref_clk); chk("ovr read", 1'b0, integ);
    u_host.wr(8'h00, 8'h03);
    @(negedge ref_clk);
    read_int_pin = 1'b0;
    repeat (2) @(negedge ref_clk); chk("ovr int", 1'b1, integ);
    u_host.wr(8'h00, 8'h00);
    @(negedge ref_clk); chk("pin read", 1'b0, integ);
    $display("test override done");
    // Sleep entry, timer override and wake
    u_host.wr(8'h02, 8'h02);
    repeat (40) @(negedge ref_clk); chk("forced read", 1'b0, slp);
    u_host.wr(8'h02, 8'h06);
    @(negedge ref_clk); chk("sleep wr", 1'b1, slp);
    read_int_pin = 1'b1;
    repeat (2) @(negedge ref_clk); chk("wake", 2'h2, {integ, slp});
    u_host.wr(8'h02, 8'h00);
    read_int_pin = 1'b0;
    repeat (20) @(negedge ref_clk); chk("timer early", 1'b0, slp);
    repeat (1) @(negedge ref_clk); chk("timer sleep", 1'b1, slp);
    $display("test sleep done");
    complete_run();
  end
endmodule
